// file: logic/sbcpc_defines.svh
`ifndef SBCPC_DEFINES_SVH
`define SBCPC_DEFINES_SVH

// ----------------------------------------------------------------
// Divider and counter figures
// ----------------------------------------------------------------
`define SBCPC_CT_DIV        32
`define SBCPC_CT_DIV_W      5
`define SBCPC_SYS_DIV       512
`define SBCPC_SYS_DIV_W     9
`define SBCPC_WDT_W         12
`define SBCPC_WDT_LOAD      12'hFFF
`define SBCPC_WDT_MSB       11
`define SBCPC_EXT_REC_F2    7
`define SBCPC_EXT_CNT_W     3
`define SBCPC_EXT_REC_LAST  3'h6

`endif

// file: logic/sbcpc_pkg.sv
package sbcpc_pkg;

    // ----------------------------------------------------------------
    // Standby states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        SBCPC_RUN      = 6'h01,
        SBCPC_WAIT     = 6'h02,
        SBCPC_WSTOP    = 6'h04,
        SBCPC_STOP     = 6'h08,
        SBCPC_WDT_REC  = 6'h10,
        SBCPC_EXT_REC  = 6'h20
    } sbcpc_state_t;

endpackage : sbcpc_pkg

// file: logic/sbcpc_sync2.sv
module sbcpc_sync2 (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_reg;

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_reg <= 1'b0;
            sync_o   <= 1'b0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule : sbcpc_sync2

// file: logic/sbcpc_tick_div.sv
module sbcpc_tick_div #(
    parameter int W = 5
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic         tick_i,
    input  wire logic         clear_i,
    output logic              pulse_o,
    output logic [W-1:0]      count_o
);

    // ----------------------------------------------------------------
    // Divide tick pulses by 2**W
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            count_o <= '0;
        else if (clear_i)
            count_o <= '0;
        else if (tick_i)
            count_o <= count_o + 1'b1;
    end

    assign pulse_o = tick_i && (&count_o) && !clear_i;

endmodule : sbcpc_tick_div

// file: logic/sbcpc_standby_ctrl.sv
// Behaviour
// - Port-select set, event mode: timer gets sub/32
// - Dummy write clears the divide-by-32 prescaler
// - No sub clock, main_div_sel_i clear: base main/2, or main/16
// - Port-select clear, source bit set: main/32
// - Wait, stop bit 0: only CPU clock held
// - Wait, stop bit 1: system and divided clocks stop
// - Sub-clock timer source keeps running in wait
// - Interrupt ends wait, CPU clock restarts at once
// - Halt stops oscillator, watchdog loaded FFF
// - Watchdog forced to f32 main or f8 sub
// - Forcing ends at watchdog top bit zero or reset
// - Reset or interrupt ends halt, clocks resume
// - Internal oscillator: CPU waits for watchdog top bit
// - Reset from halt restarts CPU clock at once
// - External clock: CPU restarts on seventh base clock
// - External bit disables internal oscillation circuit
// - Port-select bit is sticky until reset
`include "sbcpc_defines.svh"

module sbcpc_standby_ctrl (
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    input  wire logic                    sub_clk_i,
    input  wire logic                    osc_ctrl_wr_i,
    input  wire logic                    port_sel_wdata_i,
    input  wire logic                    sys_sel_wdata_i,
    input  wire logic                    prescaler_reset_i,
    input  wire logic                    main_div_sel_i,
    input  wire logic                    ct_src_sel_i,
    input  wire logic                    ct_event_mode_i,
    input  wire logic                    wait_clk_stop_i,
    input  wire logic                    main_ext_sel_i,
    input  wire logic                    sub_ext_sel_i,
    input  wire logic                    wdt_freq_sel_i,
    input  wire logic                    wait_instruction_i,
    input  wire logic                    halt_oscillator_instruction_i,
    input  wire logic                    bus_cycle_busy_i,
    input  wire logic                    irq_accept_i,
    output logic                         sub_clock_port_select_bit_o,
    output logic                         system_clock_select_bit_o,
    output logic                         main_osc_en_o,
    output logic                         sub_osc_en_o,
    output logic                         sys_clk_run_o,
    output logic                         cpu_clk_en_o,
    output logic                         peripheral_base_clock_o,
    output logic                         clock_timer_div32_source_o,
    output logic                         clock_timer_count_o,
    output logic                         wdt_tick_o,
    output logic                         wdt_forced_o,
    output logic [`SBCPC_WDT_W-1:0]      wdt_count_o,
    output sbcpc_pkg::sbcpc_state_t      standby_state_o
);

    import sbcpc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    sbcpc_state_t                   state_reg;
    sbcpc_state_t                   state_next;
    logic                           port_sel_reg;
    logic                           sys_sel_reg;
    logic                           pend_wait_reg;
    logic                           pend_halt_reg;
    logic                           sub_sync;
    logic                           sub_prev_reg;
    logic                           sub_rise;
    logic                           sub_is_sys;
    logic                           osc_run;
    logic                           sys_run;
    logic                           sys_tick;
    logic                           ct_tick;
    logic                           ct_pulse;
    logic [`SBCPC_CT_DIV_W-1:0]     ct_count;
    logic [`SBCPC_SYS_DIV_W-1:0]    sys_count;
    logic                           f8_raw;
    logic                           f16_raw;
    logic                           f32_raw;
    logic                           f512_raw;
    logic                           f2_raw;
    logic                           wdt_tick;
    logic                           ext_active;
    logic [`SBCPC_EXT_CNT_W-1:0]    ext_cnt_reg;
    logic [`SBCPC_WDT_W-1:0]        wdt_reg;
    logic                           forced_reg;
    logic                           enter_halt;

    // ----------------------------------------------------------------
    // Software control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            port_sel_reg <= 1'b0;
        else if (osc_ctrl_wr_i && port_sel_wdata_i)
            port_sel_reg <= 1'b1;
    end

    // Both bits cannot be raised by one write
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sys_sel_reg <= 1'b0;
        else if (osc_ctrl_wr_i && !(sys_sel_wdata_i && port_sel_wdata_i && !port_sel_reg))
            sys_sel_reg <= sys_sel_wdata_i;
    end

    // ----------------------------------------------------------------
    // Sub clock pin
    // ----------------------------------------------------------------
    sbcpc_sync2 u_sub_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .async_i   (sub_clk_i),
        .sync_o    (sub_sync)
    );

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sub_prev_reg <= 1'b0;
        else
            sub_prev_reg <= sub_sync;
    end

    // Sub oscillation only counts once the port is selected and running
    assign sub_rise   = sub_sync && !sub_prev_reg && port_sel_reg && osc_run;
    assign sub_is_sys = port_sel_reg && sys_sel_reg;

    // ----------------------------------------------------------------
    // Clock run levels per state
    // ----------------------------------------------------------------
    assign osc_run = (state_reg != SBCPC_STOP);
    assign sys_run = (state_reg == SBCPC_RUN) || (state_reg == SBCPC_WAIT)
                  || (state_reg == SBCPC_WDT_REC)
                  || (state_reg == SBCPC_EXT_REC);
    assign sys_tick = sys_run && (sub_is_sys ? sub_rise : 1'b1);

    // ----------------------------------------------------------------
    // Divided clocks
    // ----------------------------------------------------------------
    sbcpc_tick_div #(
        .W (`SBCPC_SYS_DIV_W)
    ) u_sys_div (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .tick_i    (sys_tick),
        .clear_i   (1'b0),
        .pulse_o   (f512_raw),
        .count_o   (sys_count)
    );

    assign f8_raw  = sys_tick && (&sys_count[2:0]);
    assign f16_raw = sys_tick && (&sys_count[3:0]);
    assign f32_raw = sys_tick && (&sys_count[4:0]);

    always_comb
    begin
        if (sub_is_sys)
            f2_raw = sys_tick && sys_count[0];
        else if (sys_sel_reg)
            f2_raw = main_div_sel_i ? f8_raw : f16_raw;
        else
            f2_raw = main_div_sel_i ? sys_tick : (sys_tick && sys_count[0]);
    end

    // ----------------------------------------------------------------
    // Clock timer source prescaler
    // ----------------------------------------------------------------
    // Sub path is not gated by the system clock, so it counts in wait
    assign ct_tick = port_sel_reg ? sub_rise : sys_run;

    sbcpc_tick_div #(
        .W (`SBCPC_CT_DIV_W)
    ) u_ct_div (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .tick_i    (ct_tick),
        .clear_i   (prescaler_reset_i),
        .pulse_o   (ct_pulse),
        .count_o   (ct_count)
    );

    // ----------------------------------------------------------------
    // Standby request capture
    // ----------------------------------------------------------------
    // Requests wait here while the current bus cycle finishes
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pend_wait_reg <= 1'b0;
        else if (wait_instruction_i)
            pend_wait_reg <= 1'b1;
        else if (state_reg == SBCPC_RUN && !bus_cycle_busy_i && !pend_halt_reg)
            pend_wait_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pend_halt_reg <= 1'b0;
        else if (halt_oscillator_instruction_i)
            pend_halt_reg <= 1'b1;
        else if (state_reg == SBCPC_RUN && !bus_cycle_busy_i)
            pend_halt_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Standby state machine
    // ----------------------------------------------------------------
    assign ext_active = sub_is_sys ? sub_ext_sel_i : main_ext_sel_i;
    assign enter_halt = (state_reg == SBCPC_RUN) && pend_halt_reg && !bus_cycle_busy_i;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SBCPC_RUN:
            begin
                if (enter_halt)
                    state_next = SBCPC_STOP;
                else if (pend_wait_reg && !bus_cycle_busy_i)
                    state_next = wait_clk_stop_i ? SBCPC_WSTOP : SBCPC_WAIT;
            end
            SBCPC_WAIT, SBCPC_WSTOP:
            begin
                if (irq_accept_i)
                    state_next = SBCPC_RUN;
            end
            SBCPC_STOP:
            begin
                if (irq_accept_i)
                    state_next = ext_active ? SBCPC_EXT_REC : SBCPC_WDT_REC;
            end
            SBCPC_WDT_REC:
            begin
                if (!wdt_reg[`SBCPC_WDT_MSB])
                    state_next = SBCPC_RUN;
            end
            SBCPC_EXT_REC:
            begin
                if (f2_raw && ext_cnt_reg == `SBCPC_EXT_REC_LAST)
                    state_next = SBCPC_RUN;
            end
            default:
                state_next = SBCPC_RUN;
        endcase
    end

    // Reset lands in run: CPU clock restarts at once
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_reg <= SBCPC_RUN;
        else
            state_reg <= state_next;
    end

    // ----------------------------------------------------------------
    // External clock recovery count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ext_cnt_reg <= '0;
        else if (state_reg != SBCPC_EXT_REC)
            ext_cnt_reg <= '0;
        else if (f2_raw)
            ext_cnt_reg <= ext_cnt_reg + 1'b1;
    end

    // ----------------------------------------------------------------
    // Watchdog count clock and counter
    // ----------------------------------------------------------------
    always_comb
    begin
        if (forced_reg)
            wdt_tick = sub_is_sys ? f8_raw : f32_raw;
        else
            wdt_tick = wdt_freq_sel_i ? f512_raw : f32_raw;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            forced_reg <= 1'b0;
        else if (enter_halt)
            forced_reg <= 1'b1;
        else if (!wdt_reg[`SBCPC_WDT_MSB])
            forced_reg <= 1'b0;
    end

    // Free-running model only; reload and timeout belong to the watchdog
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wdt_reg <= `SBCPC_WDT_LOAD;
        else if (enter_halt)
            wdt_reg <= `SBCPC_WDT_LOAD;
        else if (wdt_tick)
            wdt_reg <= wdt_reg - 1'b1;
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            main_osc_en_o   <= 1'b1;
            sub_osc_en_o    <= 1'b0;
            sys_clk_run_o   <= 1'b1;
            cpu_clk_en_o    <= 1'b1;
            standby_state_o <= SBCPC_RUN;
        end
        else
        begin
            main_osc_en_o   <= (state_next != SBCPC_STOP) && !main_ext_sel_i;
            sub_osc_en_o    <= (state_next != SBCPC_STOP) && port_sel_reg
                               && !sub_ext_sel_i;
            sys_clk_run_o   <= (state_next != SBCPC_WSTOP)
                               && (state_next != SBCPC_STOP);
            cpu_clk_en_o    <= (state_next == SBCPC_RUN);
            standby_state_o <= state_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            peripheral_base_clock_o    <= 1'b0;
            clock_timer_div32_source_o <= 1'b0;
            clock_timer_count_o        <= 1'b0;
            wdt_tick_o                 <= 1'b0;
        end
        else
        begin
            peripheral_base_clock_o    <= f2_raw;
            clock_timer_div32_source_o <= ct_pulse;
            clock_timer_count_o        <= ct_pulse && ct_event_mode_i
                                          && (port_sel_reg || ct_src_sel_i);
            wdt_tick_o                 <= wdt_tick;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sub_clock_port_select_bit_o <= 1'b0;
            system_clock_select_bit_o   <= 1'b0;
            wdt_forced_o                <= 1'b0;
            wdt_count_o                 <= `SBCPC_WDT_LOAD;
        end
        else
        begin
            sub_clock_port_select_bit_o <= port_sel_reg;
            system_clock_select_bit_o   <= sys_sel_reg;
            wdt_forced_o                <= forced_reg;
            wdt_count_o                 <= wdt_reg;
        end
    end

endmodule : sbcpc_standby_ctrl

// file: testbench/sbcpc_standby_asserts.sv
`include "sbcpc_defines.svh"

module sbcpc_standby_asserts
    import sbcpc_pkg::*;
(
    input wire logic                      clk_sys_i,
    input wire logic                      nrst_i,
    input wire logic                      main_ext_sel_i,
    input wire logic                      wait_instruction_i,
    input wire logic                      halt_oscillator_instruction_i,
    input wire logic                      bus_cycle_busy_i,
    input wire logic                      irq_accept_i,
    input wire logic                      sub_clock_port_select_bit_o,
    input wire logic                      system_clock_select_bit_o,
    input wire logic                      main_osc_en_o,
    input wire logic                      sys_clk_run_o,
    input wire logic                      cpu_clk_en_o,
    input wire logic                      wdt_forced_o,
    input wire logic [`SBCPC_WDT_W-1:0]   wdt_count_o,
    input wire sbcpc_state_t              standby_state_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------------------------------
    // Standby entry and wake
    // ----------------------------------------------------------------
    sequence s_wait_req;
        wait_instruction_i && !halt_oscillator_instruction_i && !bus_cycle_busy_i
            && standby_state_o == SBCPC_RUN;
    endsequence

    sequence s_bus_idle;
        !bus_cycle_busy_i;
    endsequence

    a_wait_entry: assert property (
        s_wait_req ##1 s_bus_idle |=> !cpu_clk_en_o)
        else $error("wait entry");
    a_wait_cpu_off: assert property (
        standby_state_o == SBCPC_WAIT |-> !cpu_clk_en_o && sys_clk_run_o)
        else $error("wait clocks");
    a_wstop_clocks_off: assert property (
        standby_state_o == SBCPC_WSTOP |-> !cpu_clk_en_o && !sys_clk_run_o)
        else $error("wstop clocks");
    a_wait_irq_wake: assert property (
        (standby_state_o == SBCPC_WAIT || standby_state_o == SBCPC_WSTOP) && irq_accept_i
        |=> cpu_clk_en_o && standby_state_o == SBCPC_RUN)
        else $error("wait wake");
    a_stop_halts: assert property (
        standby_state_o == SBCPC_STOP |-> !main_osc_en_o && !cpu_clk_en_o && !sys_clk_run_o)
        else $error("halt clocks");
    a_stop_wdt_load: assert property (
        standby_state_o == SBCPC_STOP [*2] |-> wdt_count_o == 12'hFFF)
        else $error("wdt load");
    a_wdt_rec_hold: assert property (
        standby_state_o == SBCPC_WDT_REC |-> !cpu_clk_en_o && wdt_count_o[`SBCPC_WDT_MSB])
        else $error("wdt recovery");
    a_wdt_force_end: assert property (
        $fell(wdt_count_o[`SBCPC_WDT_MSB]) |-> ##[0:1] !wdt_forced_o)
        else $error("wdt force");
    // Slow system clocks excluded from this bound
    a_ext_wake_bound: assert property (
        $rose(standby_state_o == SBCPC_EXT_REC) && !system_clock_select_bit_o
        |-> ##[10:40] standby_state_o == SBCPC_RUN)
        else $error("ext recovery");
    a_ext_osc_off: assert property (
        $past(main_ext_sel_i) |-> !main_osc_en_o)
        else $error("ext osc");
    a_port_sticky: assert property (
        !$fell(sub_clock_port_select_bit_o))
        else $error("port sticky");
endmodule : sbcpc_standby_asserts

bind sbcpc_standby_ctrl sbcpc_standby_asserts i_sbcpc_standby_asserts (
    .clk_sys_i, .nrst_i, .main_ext_sel_i, .wait_instruction_i,
    .halt_oscillator_instruction_i, .bus_cycle_busy_i, .irq_accept_i,
    .sub_clock_port_select_bit_o, .system_clock_select_bit_o, .main_osc_en_o,
    .sys_clk_run_o, .cpu_clk_en_o, .wdt_forced_o, .wdt_count_o, .standby_state_o
);

// file: testbench/testbench.sv
`include "sbcpc_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sbcpc_pkg::*;

    logic clk_sys_i = 1'b0, nrst_i = 1'b0, sub_clk_i = 1'b0, osc_ctrl_wr_i = 1'b0;
    logic port_sel_wdata_i = 1'b0, sys_sel_wdata_i = 1'b0, prescaler_reset_i = 1'b0;
    logic main_div_sel_i = 1'b0, ct_src_sel_i = 1'b0, ct_event_mode_i = 1'b0;
    logic wait_clk_stop_i = 1'b0, main_ext_sel_i = 1'b0, sub_ext_sel_i = 1'b0;
    logic wdt_freq_sel_i = 1'b0, wait_instruction_i = 1'b0, bus_cycle_busy_i = 1'b0;
    logic halt_oscillator_instruction_i = 1'b0, irq_accept_i = 1'b0;
    logic sub_clock_port_select_bit_o, system_clock_select_bit_o, main_osc_en_o;
    logic sub_osc_en_o, sys_clk_run_o, cpu_clk_en_o, peripheral_base_clock_o;
    logic clock_timer_div32_source_o, clock_timer_count_o, wdt_tick_o, wdt_forced_o;
    logic [`SBCPC_WDT_W-1:0] wdt_count_o;
    sbcpc_state_t            standby_state_o;
    int                      errors = 0;
    int                      checks = 0;
    int                      n;

    always #50 clk_sys_i = ~clk_sys_i;
    always #300 sub_clk_i = ~sub_clk_i;

    sbcpc_standby_ctrl i_sbcpc_standby_ctrl (
        .clk_sys_i, .nrst_i, .sub_clk_i, .osc_ctrl_wr_i, .port_sel_wdata_i,
        .sys_sel_wdata_i, .prescaler_reset_i, .main_div_sel_i, .ct_src_sel_i,
        .ct_event_mode_i, .wait_clk_stop_i, .main_ext_sel_i, .sub_ext_sel_i,
        .wdt_freq_sel_i, .wait_instruction_i, .halt_oscillator_instruction_i,
        .bus_cycle_busy_i, .irq_accept_i, .sub_clock_port_select_bit_o,
        .system_clock_select_bit_o, .main_osc_en_o, .sub_osc_en_o, .sys_clk_run_o,
        .cpu_clk_en_o, .peripheral_base_clock_o, .clock_timer_div32_source_o,
        .clock_timer_count_o, .wdt_tick_o, .wdt_forced_o, .wdt_count_o, .standby_state_o
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_st(input sbcpc_state_t got, input sbcpc_state_t exp);
        chk(12'(got), 12'(exp), "state");
    endtask : chk_st

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic hang(input int k, input int lim);
        if (k >= lim)
        begin
            errors++;
            $display("FAIL %0t timeout", $time);
            finish_test();
        end
    endtask : hang

    // Gap between base or timer pulses
    task automatic gap(input bit ct, output int g);
        int k = 0;
        do cyc(1); while ((ct ? clock_timer_count_o : peripheral_base_clock_o) !== 1'b1 && ++k < 999);
        g = 0;
        do cyc(1); while ((ct ? clock_timer_count_o : peripheral_base_clock_o) !== 1'b1 && ++g < 999);
        hang(k > g ? k : g, 999);
        g++;
    endtask : gap

    task automatic wait_cpu(input int lim, output int k);
        k = 0;
        do cyc(1); while (cpu_clk_en_o !== 1'b1 && ++k < lim);
        hang(k, lim);
    endtask : wait_cpu

    task automatic wr_ctrl(input logic p, input logic s);
        @(posedge clk_sys_i);
        port_sel_wdata_i <= p;
        sys_sel_wdata_i  <= s;
        osc_ctrl_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        osc_ctrl_wr_i    <= 1'b0;
        cyc(2);
    endtask : wr_ctrl

    task automatic enter(input bit halt);
        @(posedge clk_sys_i);
        wait_instruction_i            <= !halt;
        halt_oscillator_instruction_i <= halt;
        @(posedge clk_sys_i);
        wait_instruction_i            <= 1'b0;
        halt_oscillator_instruction_i <= 1'b0;
        cyc(3);
    endtask : enter

    task automatic irq;
        @(posedge clk_sys_i);
        irq_accept_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_accept_i <= 1'b0;
        #1;
    endtask : irq

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_base;
        gap(0, n);
        chk(12'(n), 12'h2, "f2 main/2");
        @(posedge clk_sys_i);
        main_div_sel_i <= 1'b1;
        gap(0, n);
        chk(12'(n), 12'h1, "f2 main");
        @(posedge clk_sys_i);
        main_div_sel_i <= 1'b0;
        wr_ctrl(1'b0, 1'b1);
        chk(system_clock_select_bit_o, 12'h1, "sys sel");
        gap(0, n);
        chk(12'(n), 12'h10, "main/16");
        wr_ctrl(1'b0, 1'b0);
    endtask : t_base

    task automatic t_presc;
        ct_src_sel_i    <= 1'b1;
        ct_event_mode_i <= 1'b1;
        gap(1, n);
        chk(12'(n), 12'h20, "main/32");
        cyc(14);
        @(posedge clk_sys_i);
        prescaler_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        prescaler_reset_i <= 1'b0;
        n = 0;
        do cyc(1); while (clock_timer_div32_source_o !== 1'b1 && ++n < 60);
        chk(12'(n >= 31 && n <= 34), 12'h1, "presc");
        ct_event_mode_i <= 1'b0;
        n = 0;
        repeat (40)
        begin
            cyc(1);
            n += int'(clock_timer_count_o === 1'b1);
        end
        chk(12'(n), 12'h0, "no event");
    endtask : t_presc

    task automatic t_wait(input logic s);
        @(posedge clk_sys_i);
        wait_clk_stop_i  <= s;
        bus_cycle_busy_i <= !s;
        enter(1'b0);
        chk(cpu_clk_en_o, 12'(!s), "entry");
        @(posedge clk_sys_i);
        bus_cycle_busy_i <= 1'b0;
        cyc(3);
        chk(cpu_clk_en_o, 12'h0, "cpu wait");
        chk_st(standby_state_o, s ? SBCPC_WSTOP : SBCPC_WAIT);
        chk(sys_clk_run_o, 12'(!s), "sys wait");
        n = 0;
        repeat (20)
        begin
            cyc(1);
            n += int'(peripheral_base_clock_o === 1'b1);
        end
        chk(12'(n == 0), 12'(s), "div wait");
        irq();
        chk(cpu_clk_en_o, 12'h1, "cpu wake");
        chk_st(standby_state_o, SBCPC_RUN);
        @(posedge clk_sys_i);
        wait_clk_stop_i <= 1'b0;
    endtask : t_wait

    task automatic t_stop_ext;
        @(posedge clk_sys_i);
        main_ext_sel_i <= 1'b1;
        enter(1'b1);
        chk_st(standby_state_o, SBCPC_STOP);
        chk(wdt_count_o, 12'hFFF, "wdt load");
        chk(cpu_clk_en_o, 12'h0, "cpu halt");
        irq();
        wait_cpu(60, n);
        chk(12'(n >= 12 && n <= 16), 12'h1, "ext wake");
        chk(sys_clk_run_o, 12'h1, "resume");
        chk(main_osc_en_o, 12'h0, "osc off");
        @(posedge clk_sys_i);
        main_ext_sel_i <= 1'b0;
    endtask : t_stop_ext

    task automatic t_stop_wdt;
        enter(1'b1);
        irq();
        cyc(1);
        chk_st(standby_state_o, SBCPC_WDT_REC);
        chk(wdt_forced_o, 12'h1, "forced");
        wait_cpu(70000, n);
        chk(12'(n > 65400 && n < 65700), 12'h1, "wdt wake");
        chk(wdt_count_o[`SBCPC_WDT_MSB], 12'h0, "wdt msb");
        cyc(2);
        chk(wdt_forced_o, 12'h0, "released");
    endtask : t_stop_wdt

    task automatic t_stop_reset;
        enter(1'b1);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        cyc(3);
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        cyc(1);
        chk(cpu_clk_en_o, 12'h1, "cpu reset");
        chk_st(standby_state_o, SBCPC_RUN);
    endtask : t_stop_reset

    task automatic t_port;
        wr_ctrl(1'b1, 1'b1);
        chk(sub_clock_port_select_bit_o, 12'h1, "port set");
        chk(system_clock_select_bit_o, 12'h0, "joint");
        wr_ctrl(1'b0, 1'b0);
        chk(sub_clock_port_select_bit_o, 12'h1, "sticky");
        ct_src_sel_i    <= 1'b0;
        ct_event_mode_i <= 1'b1;
        wait_clk_stop_i <= 1'b1;
        enter(1'b0);
        gap(1, n);
        chk(12'(n), 12'hC0, "sub wait");
    endtask : t_port

    initial
    begin
        cyc(16);
        chk(cpu_clk_en_o, 12'h1, "cpu rst");
        chk(wdt_count_o, 12'hFFF, "wdt rst");
        chk_st(standby_state_o, SBCPC_RUN);
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        cyc(2);
        chk(main_osc_en_o, 12'h1, "osc on");
        t_base();
        t_presc();
        t_wait(1'b0);
        t_wait(1'b1);
        t_stop_ext();
        t_stop_wdt();
        t_stop_reset();
        t_port();
        finish_test();
    end
endmodule : testbench
